// ===== src/acf_map.svh
// Purpose: Constants of the serial-frame and power-mode control block.
// Assumes: Included by the control module; definitions only.
// Notes:   Edge counts are falling link-clock edges since the select fell.
//
// Behaviour
// - Rise between 10th and 16th edge: stay normal, abort, release output.
// - Output floats after sixteen cycles; host waits quiet time before next frame.
// - Rise between 2nd and 10th edge: enter shutdown, abort, float output.
// - Rise before 2nd edge leaves the mode unchanged.
// - Select falling in shutdown starts wake; first result unusable, second valid.
// - In wake frame, rise before 10th edge returns to shutdown.
// - Full power is reached 16 clock cycles after the wake frame begins.
// - One dummy conversion after power-on or wake; later results are proper.
// - Frame is three zeros, eight data bits msb first, four zeros; the code sends five trailing zeros before the output floats at the 16th edge.
// - Select fall holds the input, starts conversion, drives the output; the code holds the input at the first falling link-clock edge instead.
// - Result is straight binary, zero lowest, all ones highest.
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH

`define ACF_DATA_BITS 8
`define ACF_CNT_BITS 5
`define ACF_EDGE_MODE 5'h02
`define ACF_EDGE_NORMAL 5'h0A
`define ACF_EDGE_FULL 5'h10
`define ACF_LEAD_ZEROS 5'h03
`define ACF_DATA_LAST 5'h0A

`endif

// ===== src/acf_pkg.sv
// Purpose: Types of the serial-frame and power-mode control block.
// Assumes: Nothing.
// Notes:   Constants live in acf_map.svh.
package acf_pkg;

    // Threshold flags of one frame, monotonic while the select is low
    typedef struct packed {
        logic reach16;
        logic reach10;
        logic reach2;
    } acf_flags_type;

    typedef enum logic [1:0] {
        ACF_NORMAL   = 2'b00,
        ACF_SHUTDOWN = 2'b01,
        ACF_WAKING   = 2'b10
    } acf_mode_type;

    typedef struct packed {
        logic       dummy;
        logic [7:0] data;
    } acf_word_type;

endpackage

// ===== src/acf_ctrl.sv
// Purpose: Serial frame and power-mode control of a sampling converter.
// Assumes: Select idles high at start; input word stable around the frame start.
// Notes:   Link logic on the serial clock, mode logic on i_clk.
`timescale 1ns/1ps
`include "acf_map.svh"
`default_nettype none

module acf_ctrl (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    output logic o_serial_out,
    output logic o_serial_oe,
    // Converter core
    input wire logic [7:0] i_sample,
    // Status
    output logic o_shutdown,
    output logic o_full_power,
    output acf_pkg::acf_word_type o_word,
    output logic o_word_valid
);

    // ==========================================================
    // Link domain
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [7:0] sample_q;
    logic serial_q;
    acf_pkg::acf_flags_type flags_q;
    acf_pkg::acf_flags_type held_q;

    function automatic logic frame_bit(input logic [4:0] n, input logic [7:0] w);
        logic b;
        b = 1'b0;
        if (n >= `ACF_LEAD_ZEROS && n <= `ACF_DATA_LAST) begin
            b = w[3'(`ACF_DATA_LAST - n)];
        end
        return b;
    endfunction

    assign cnt_d = (cnt_q == `ACF_EDGE_FULL) ? cnt_q : 5'(cnt_q + 5'h01);

    // Select high clears the count, so every frame starts from zero
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Live flags; the select rise clears them, so they may be too short for i_clk
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            flags_q <= '0;
        end else begin
            flags_q.reach2 <= cnt_d >= `ACF_EDGE_MODE;
            flags_q.reach10 <= cnt_d >= `ACF_EDGE_NORMAL;
            flags_q.reach16 <= cnt_d >= `ACF_EDGE_FULL;
        end
    end

    // Reach of the frame as the select rose, held until the next rise; it is stable
    // long before the synchronised rise reaches the mode logic, which reads it then
    always_ff @(posedge i_cs_n) begin
        held_q <= flags_q;
    end

    // Input held at the first edge of the frame, straight binary
    always_ff @(negedge i_sclk) begin
        if (cnt_q == 5'h00) begin
            sample_q <= i_sample;
        end
    end

    // Bits change on falling edges: 3 zeros, 8 data msb first, then zeros
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            serial_q <= 1'b0;
        end else begin
            serial_q <= frame_bit(cnt_d, (cnt_q == 5'h00) ? i_sample : sample_q);
        end
    end

    assign o_serial_out = serial_q;
    // Driven from select fall; floats on select rise or after the 16th edge
    assign o_serial_oe = ~i_cs_n & ~flags_q.reach16;

    // ==========================================================
    // System domain: crossings
    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    acf_pkg::acf_flags_type flag_meta_q;
    acf_pkg::acf_flags_type flag_sync_q;
    acf_pkg::acf_flags_type seen_q;
    acf_pkg::acf_flags_type seen_all;
    logic cs_fall;
    logic cs_rise;
    logic word_evt;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
            flag_meta_q <= '0;
            flag_sync_q <= '0;
        end else begin
            cs_meta_q <= i_cs_n;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
            flag_meta_q <= flags_q;
            flag_sync_q <= flag_meta_q;
        end
    end

    assign cs_fall = cs_prev_q & ~cs_sync_q;
    assign cs_rise = ~cs_prev_q & cs_sync_q;
    // The held reach joins at the rise, catching a frame whose live flags were too brief
    assign seen_all = acf_pkg::acf_flags_type'(seen_q | flag_sync_q | ({3{cs_rise}} & held_q));
    assign word_evt = seen_all.reach16 & ~seen_q.reach16;

    // Sticky flags hold the frame's reach even after the pin clears them
    always_ff @(posedge i_clk) begin
        if (i_reset || cs_fall) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_all;
        end
    end

    // ==========================================================
    // Mode machine
    acf_pkg::acf_mode_type mode_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_q <= acf_pkg::ACF_NORMAL;
        end else if (cs_fall && mode_q == acf_pkg::ACF_SHUTDOWN) begin
            mode_q <= acf_pkg::ACF_WAKING;
        end else if (cs_rise) begin
            case (mode_q)
                acf_pkg::ACF_WAKING: begin
                    mode_q <= seen_all.reach10 ? acf_pkg::ACF_NORMAL : acf_pkg::ACF_SHUTDOWN;
                end
                acf_pkg::ACF_NORMAL: begin
                    if (seen_all.reach2 && !seen_all.reach10) begin
                        mode_q <= acf_pkg::ACF_SHUTDOWN;
                    end else begin
                        mode_q <= acf_pkg::ACF_NORMAL;
                    end
                end
                acf_pkg::ACF_SHUTDOWN: begin
                    mode_q <= acf_pkg::ACF_SHUTDOWN;
                end
                default: begin
                    mode_q <= acf_pkg::ACF_NORMAL;
                end
            endcase
        end
    end

    assign o_shutdown = mode_q == acf_pkg::ACF_SHUTDOWN;

    // Dummy marker: set at power-on and at wake, cleared by a select rise after a frame reached the 10th edge
    logic dummy_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dummy_q <= 1'b1;
        end else if (cs_fall && mode_q == acf_pkg::ACF_SHUTDOWN) begin
            dummy_q <= 1'b1;
        end else if (cs_rise && seen_all.reach10) begin
            dummy_q <= 1'b0;
        end
    end

    // Full power after 16 edges of the wake frame; lost on shutdown
    always_ff @(posedge i_clk) begin
        if (i_reset || mode_q == acf_pkg::ACF_SHUTDOWN) begin
            o_full_power <= 1'b0;
        end else if (word_evt) begin
            o_full_power <= 1'b1;
        end
    end

    // Completed word; sample_q is stable since the frame's first edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_word <= '0;
            o_word_valid <= 1'b0;
        end else begin
            o_word_valid <= word_evt;
            if (word_evt) begin
                o_word.data <= sample_q;
                o_word.dummy <= dummy_q;
            end
        end
    end

    // ==========================================================
    // Assertions
    property p_shut_entry;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && mode_q == acf_pkg::ACF_NORMAL && seen_all.reach2 && !seen_all.reach10
        |=> mode_q == acf_pkg::ACF_SHUTDOWN;
    endproperty
    a_shut_entry: assert property (p_shut_entry) else $error("no shutdown on early rise");

    property p_glitch_keep;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && mode_q != acf_pkg::ACF_WAKING && !seen_all.reach2 |=> $stable(mode_q);
    endproperty
    a_glitch_keep: assert property (p_glitch_keep) else $error("mode changed on short frame");

    property p_stay_normal;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && mode_q == acf_pkg::ACF_NORMAL && seen_all.reach10 |=> mode_q == acf_pkg::ACF_NORMAL;
    endproperty
    a_stay_normal: assert property (p_stay_normal) else $error("left normal after tenth edge");

    property p_wake_abort;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && mode_q == acf_pkg::ACF_WAKING && !seen_all.reach10 |=> mode_q == acf_pkg::ACF_SHUTDOWN;
    endproperty
    a_wake_abort: assert property (p_wake_abort) else $error("short wake frame did not return");

    property p_wake_start;
        @(posedge i_clk) disable iff (i_reset)
        cs_fall && mode_q == acf_pkg::ACF_SHUTDOWN |=> mode_q == acf_pkg::ACF_WAKING && dummy_q;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("select fall did not wake");

    property p_wake_dummy;
        @(posedge i_clk) disable iff (i_reset)
        word_evt && mode_q == acf_pkg::ACF_WAKING |=> o_word_valid && o_word.dummy;
    endproperty
    a_wake_dummy: assert property (p_wake_dummy) else $error("wake result not flagged");

    property p_dummy_once;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && seen_all.reach10 ##1 !cs_fall [*2] |-> !dummy_q;
    endproperty
    a_dummy_once: assert property (p_dummy_once) else $error("dummy kept after conversion");

    property p_full_power;
        @(posedge i_clk) disable iff (i_reset)
        word_evt && mode_q == acf_pkg::ACF_WAKING |=> o_full_power;
    endproperty
    a_full_power: assert property (p_full_power) else $error("no full power after wake frame");

    property p_count_restart;
        @(posedge i_clk) disable iff (i_reset)
        cs_fall |=> seen_q == '0;
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("frame flags not cleared");

    property p_float_end;
        @(negedge i_sclk) disable iff (i_cs_n)
        cnt_q == `ACF_EDGE_FULL |-> !o_serial_oe;
    endproperty
    a_float_end: assert property (p_float_end) else $error("output driven after word");

    property p_lead_zero;
        @(negedge i_sclk) disable iff (i_cs_n)
        cnt_q < `ACF_LEAD_ZEROS |-> !o_serial_out && o_serial_oe;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");

    c_shutdown: cover property (@(posedge i_clk) disable iff (i_reset)
        mode_q == acf_pkg::ACF_NORMAL ##1 mode_q == acf_pkg::ACF_SHUTDOWN);
    c_wake: cover property (@(posedge i_clk) disable iff (i_reset)
        mode_q == acf_pkg::ACF_WAKING ##1 mode_q == acf_pkg::ACF_NORMAL);
    c_word: cover property (@(posedge i_clk) disable iff (i_reset) o_word_valid && !o_word.dummy);

endmodule // acf_ctrl

`default_nettype wire

// ===== tb/acf_host.sv
// Purpose: Host serial controller model for the converter link.
// Assumes: Link clock idles low and runs only inside frames, 6 ns period.
// Notes:   Bits are taken on rising link-clock edges.
`timescale 1ns/1ps
`default_nettype none

module acf_host (
    // Link pins
    output logic o_sclk,
    output logic o_cs_n,
    input wire logic i_serial_out,
    input wire logic i_serial_oe
);
    logic last_q = 1'b0;
    logic line;

    // No pull on the pin: a floating line shows a value that keeps changing
    assign line = i_serial_oe ? i_serial_out : ~last_q;

    always @(posedge o_sclk) last_q <= line;

    // Select starts low for a moment: its rise clears the link logic, which has no reset
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        #1 o_cs_n = 1'b1;
    end

    // =========================================================
    // One frame of n falling edges
    task automatic frame(input int n, output logic [15:0] bits, output logic oe_s, output logic oe_e);
        bits = 16'h0000;
        o_cs_n = 1'b0;
        #1 oe_s = i_serial_oe;
        #2;
        for (int k = 0; k < n; k++) begin
            o_sclk = 1'b1;
            if (k < 16) bits[k] = line;
            #3 o_sclk = 1'b0;
            #3;
        end
        oe_e = i_serial_oe;
        o_cs_n = 1'b1;
        // Gap covers quiet time and lets the slow side see the rise
        #300;
    endtask
endmodule // acf_host
`default_nettype wire

// ===== tb/acf_ctrl_test.sv
// Purpose: Self-checking bench of the frame and power-mode control.
// Assumes: Host model drives the link; bench drives clock, reset, sample.
// Notes:   Words are collected from the status side as they pulse.
`timescale 1ns/1ps
`default_nettype none

module acf_ctrl_test;
    logic i_clk, i_reset, sclk, cs_n, sout, soe, shutdown, full_power, word_valid, oe_s, oe_e;
    logic [7:0] i_sample;
    logic [15:0] bits;
    acf_pkg::acf_word_type word, word_q;
    int fails = 0;
    int num_checks = 0;
    int words = 0;
    int got_words;

    acf_ctrl i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .o_serial_out(sout),
        .o_serial_oe(soe), .i_sample(i_sample), .o_shutdown(shutdown), .o_full_power(full_power),
        .o_word(word), .o_word_valid(word_valid));
    acf_host i_host (.o_sclk(sclk), .o_cs_n(cs_n), .i_serial_out(sout), .i_serial_oe(soe));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    always @(posedge i_clk) if (word_valid === 1'b1) begin
        word_q <= word;
        words <= words + 1;
    end

    // =========================================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_bits(input logic [7:0] d);
        logic [15:0] e;
        e = 16'h0000;
        for (int j = 0; j < 8; j++) e[3 + j] = d[7 - j];
        return e;
    endfunction

    task automatic run(input int n, input logic [7:0] d);
        int start;
        @(posedge i_clk) i_sample <= d;
        @(posedge i_clk);
        start = words;
        i_host.frame(n, bits, oe_s, oe_e);
        got_words = words - start;
    endtask

    // =========================================================
    // Scenarios
    task automatic t_power_on();
        run(16, 8'hA5);
        check(16'(oe_s), 16'h0001, "drive at select fall");
        check(bits, exp_bits(8'hA5), "frame bits");
        check(16'(oe_e), 16'h0000, "float after 16 edges");
        check(16'(got_words), 16'h0001, "one word");
        check(16'(word_q), 16'h01A5, "first word flagged");
        run(16, 8'hFF);
        check(bits, exp_bits(8'hFF), "frame bits full scale");
        check(16'(word_q), 16'h00FF, "second word proper");
        check(16'(full_power), 16'h0001, "full power");
        run(18, 8'h3C);
        check(bits, exp_bits(8'h3C), "edges past sixteen ignored");
        check(16'(oe_e), 16'h0000, "still floating at 18th edge");
        check(16'(got_words), 16'h0001, "one word for long frame");
        check(16'(word_q), 16'h003C, "long frame word");
        $display("test power_on done");
    endtask

    task automatic t_glitch_abort();
        run(1, 8'h00);
        check(16'(shutdown), 16'h0000, "glitch keeps mode");
        check(16'(got_words), 16'h0000, "no word on glitch");
        run(10, 8'h5A);
        check(16'(oe_e), 16'h0001, "driving until rise");
        check(16'(soe), 16'h0000, "float after rise");
        check(16'(shutdown), 16'h0000, "abort stays normal");
        check(16'(got_words), 16'h0000, "truncated word");
        $display("test glitch_abort done");
    endtask

    task automatic t_sleep_wake();
        run(2, 8'h00);
        check(16'(shutdown), 16'h0001, "enter shutdown");
        check(16'(soe), 16'h0000, "float in shutdown");
        check(16'(full_power), 16'h0000, "power off");
        run(9, 8'h00);
        check(16'(shutdown), 16'h0001, "short wake returns");
        run(16, 8'h81);
        check(16'(shutdown), 16'h0000, "wake to normal");
        check(16'(word_q), 16'h0181, "wake word unusable");
        check(16'(full_power), 16'h0001, "full power after wake");
        run(16, 8'h00);
        check(16'(word_q), 16'h0000, "second wake word valid");
        $display("test sleep_wake done");
    endtask

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        i_reset = 1'b1;
        i_sample = 8'h00;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        t_power_on();
        t_glitch_abort();
        t_sleep_wake();
        give_verdict();
    end

    // Whole run is a few microseconds; this is far beyond it
    initial begin
        #100000;
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // acf_ctrl_test
`default_nettype wire
